// File: design/console_typewriter_coupler.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module console_typewriter_coupler #(
   parameter int unsigned READER_CYC   = coupler_pkg::READER_BUSY_MS * coupler_pkg::CLK_KHZ,
   parameter int unsigned KEYBOARD_CYC = coupler_pkg::KEYBOARD_BUSY_MS * coupler_pkg::CLK_KHZ,
   parameter int unsigned OUTPUT_CYC   = coupler_pkg::OUTPUT_BUSY_MS * coupler_pkg::CLK_KHZ,
   parameter int unsigned TURNOFF_CYC  = coupler_pkg::TURNOFF_MS * coupler_pkg::CLK_KHZ
) (
   // Clock, reset and enable
   input  wire logic                         core_clk,
   input  wire logic                         arst_n,
   input  wire logic                         clkEn,
   // I/O instruction port
   input  wire logic                         ioStart,
   input  wire logic [5:0]                   ioUnit,
   input  wire logic [1:0]                   ioOp,
   input  wire logic [15:0]                  ioWord,
   output      logic                         ioBusBusy,
   output      logic                         ioDone,
   output      logic                         ioSkip,
   output      logic [15:0]                  ioInData,
   // Priority interrupt requests, group 0
   output      logic                         irqLevel11,
   output      logic                         irqLevel12,
   // Typewriter pins
   input  wire logic [7:0]                   devChar,
   input  wire logic                         kbdStrobe,
   input  wire logic                         rdrStrobe,
   output      logic                         rdrAdvance,
   output      logic [7:0]                   prtChar,
   output      logic                         prtStrobe,
   // Register port
   input  wire logic [1:0]                   regAddr,
   input  wire logic [coupler_pkg::REG_W-1:0] regWrData,
   input  wire logic                         regWr,
   input  wire logic                         regRd,
   output      logic [coupler_pkg::REG_W-1:0] regRdData,
   output      logic                         irq
);

   localparam int TW = coupler_pkg::TMR_W;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [7:0] charMeta;
   logic [7:0] charSync;
   logic [2:0] kbdSync;
   logic [2:0] rdrSync;
   logic       kbdEdge;
   logic       rdrEdge;

   // Two stages before use; the third stage only feeds the edge detect
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         charMeta <= 8'h00;
         charSync <= 8'h00;
         kbdSync  <= 3'h0;
         rdrSync  <= 3'h0;
      end else if (clkEn) begin
         charMeta <= devChar;
         charSync <= charMeta;
         kbdSync  <= {kbdSync[1:0], kbdStrobe};
         rdrSync  <= {rdrSync[1:0], rdrStrobe};
      end
   end

   assign kbdEdge = kbdSync[1] & ~kbdSync[2];
   assign rdrEdge = rdrSync[1] & ~rdrSync[2];

   // ****************************************************************
   // Timers
   // ****************************************************************
   timer_if #(.W(TW)) inTmr ();
   timer_if #(.W(TW)) outTmr ();

   coupler_timer #(.W(TW)) u_inTimer (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .tmr      (inTmr)
   );

   coupler_timer #(.W(TW)) u_outTimer (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .clkEn    (clkEn),
      .tmr      (outTmr)
   );

   // ****************************************************************
   // State
   // ****************************************************************
   coupler_pkg::seq_e  seqState;
   logic [2:0]         seqCount;
   logic               inConn;
   logic               outConn;
   logic               rdrMode;
   logic               kbdMode;
   logic [7:0]         inBuf;
   logic               inFull;
   logic               outFull;
   logic               fetchPend;
   logic [coupler_pkg::REG_W-1:0] status;
   logic [coupler_pkg::REG_W-1:0] mask;

   // Check that a command word has none of its 16 bits set at all
   function automatic logic word_empty(input logic [15:0] w);
      return (w == 16'h0000);
   endfunction : word_empty

   // ****************************************************************
   // Instruction decode
   // ****************************************************************
   logic take;
   logic isCmd;
   logic isIn;
   logic isOut;
   logic cmdTest;
   logic accept;
   logic setMode;
   logic keyLoad;
   logic rdrLoad;
   logic inEvent;
   logic outEvent;

   assign take  = clkEn & ioStart & (seqState == coupler_pkg::SEQ_IDLE)
                  & (ioUnit == coupler_pkg::UNIT_NUM);
   assign isCmd = take & (ioOp == coupler_pkg::OP_COMMAND);
   assign isIn  = take & (ioOp == coupler_pkg::OP_INPUT);
   assign isOut = take & (ioOp == coupler_pkg::OP_OUTPUT);
   assign cmdTest = isCmd & word_empty(ioWord);

   // Skip decision: input needs a full buffer, output an empty one
   always_comb begin
      accept = 1'b0;
      if (cmdTest) begin
         accept = ~outFull & ~inTmr.running;
      end else if (isCmd) begin
         accept = 1'b1;
      end else if (isIn) begin
         accept = inFull;
      end else if (isOut) begin
         accept = ~outFull;
      end
   end

   assign setMode = isCmd & ~cmdTest & (ioWord[coupler_pkg::CMD_READER]
                    | ioWord[coupler_pkg::CMD_KEYBOARD] | ioWord[coupler_pkg::CMD_MODE_CLR]);

   // Keyboard characters are paced by the keyboard busy time
   assign keyLoad = kbdMode & kbdEdge & ~inTmr.running & ~setMode;
   // A reader character is only taken while its fetch is pending
   assign rdrLoad = rdrMode & fetchPend & rdrEdge & ~setMode;

   // Input timer starts on reader fetches and on keyboard characters
   always_comb begin
      inTmr.start = 1'b0;
      inTmr.load  = TW'(KEYBOARD_CYC);
      if ((setMode & ioWord[coupler_pkg::CMD_READER] & ~ioWord[coupler_pkg::CMD_KEYBOARD]
           & ~ioWord[coupler_pkg::CMD_MODE_CLR]) | (isIn & accept & rdrMode)) begin
         inTmr.start = 1'b1;
         inTmr.load  = TW'(READER_CYC);
      end else if (keyLoad) begin
         inTmr.start = 1'b1;
      end
   end

   // Output busy time covers print and punch of one character
   assign outTmr.start = isOut & accept;
   assign outTmr.load  = TW'(OUTPUT_CYC);

   assign inEvent  = keyLoad | rdrLoad
                     | (isCmd & ioWord[coupler_pkg::CMD_CONNECT]
                        & ioWord[coupler_pkg::CMD_IN_SEL]);
   assign outEvent = (outFull & outTmr.done)
                     | (isCmd & ioWord[coupler_pkg::CMD_CONNECT]
                        & ioWord[coupler_pkg::CMD_OUT_SEL]);

   // ****************************************************************
   // Bus sequencer
   // ****************************************************************

   // Every instruction to the unit holds the bus four cycles, the take and three busy, the answer
   // comes in the cycle after the last; state effects were applied on the first
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         seqState  <= coupler_pkg::SEQ_IDLE;
         seqCount  <= 3'h0;
         ioBusBusy <= 1'b0;
         ioDone    <= 1'b0;
         ioSkip    <= 1'b0;
         ioInData  <= 16'h0000;
      end else if (clkEn) begin
         ioDone <= 1'b0;
         unique case (seqState)
            coupler_pkg::SEQ_IDLE: begin
               if (take) begin
                  seqState  <= coupler_pkg::SEQ_XFER;
                  seqCount  <= 3'h0;
                  ioBusBusy <= 1'b1;
                  ioSkip    <= accept;
                  if (isIn & accept) begin
                     ioInData <= {8'h00, inBuf};
                  end
               end
            end
            coupler_pkg::SEQ_XFER: begin
               seqCount <= seqCount + 3'h1;
               if (seqCount == coupler_pkg::XFER_LAST - 3'h1) begin
                  seqState  <= coupler_pkg::SEQ_IDLE;
                  ioBusBusy <= 1'b0;
                  ioDone    <= 1'b1;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Interrupt connection and input mode
   // ****************************************************************

   // Bit 1 gives the level for whichever interrupts bits 2 and 3 select
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         inConn  <= 1'b0;
         outConn <= 1'b0;
      end else if (isCmd) begin
         if (ioWord[coupler_pkg::CMD_IN_SEL]) begin
            inConn <= ioWord[coupler_pkg::CMD_CONNECT];
         end
         if (ioWord[coupler_pkg::CMD_OUT_SEL]) begin
            outConn <= ioWord[coupler_pkg::CMD_CONNECT];
         end
      end
   end

   // Mode clear wins over keyboard, keyboard over reader, if several are set
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdrMode <= 1'b0;
         kbdMode <= 1'b0;
      end else if (setMode) begin
         if (ioWord[coupler_pkg::CMD_MODE_CLR]) begin
            rdrMode <= 1'b0;
            kbdMode <= 1'b0;
         end else if (ioWord[coupler_pkg::CMD_KEYBOARD]) begin
            rdrMode <= 1'b0;
            kbdMode <= 1'b1;
         end else begin
            rdrMode <= 1'b1;
            kbdMode <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Input buffer
   // ****************************************************************

   // A character read while the buffer is full overwrites it; software
   // that leaves the reader running loses the fetched tape character when the next mode command clears the buffer
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         inBuf  <= 8'h00;
         inFull <= 1'b0;
      end else if (clkEn) begin
         if (setMode) begin
            inBuf  <= 8'h00;
            inFull <= 1'b0;
         end else if (keyLoad | rdrLoad) begin
            inBuf  <= charSync;
            inFull <= 1'b1;
         end else if (isIn & accept) begin
            inFull <= 1'b0;
         end
      end
   end

   // Reader fetch: advance the tape once the turn-off window has passed
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fetchPend  <= 1'b0;
         rdrAdvance <= 1'b0;
      end else if (clkEn) begin
         rdrAdvance <= 1'b0;
         if (setMode) begin
            fetchPend <= 1'b0;
         end else if (rdrLoad) begin
            fetchPend <= 1'b0;
         end else if (rdrMode & inTmr.running & ~fetchPend
                      & (inTmr.remain == TW'(READER_CYC - TURNOFF_CYC))) begin
            fetchPend  <= 1'b1;
            rdrAdvance <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Output buffer
   // ****************************************************************

   // Printer gets the character at once; the buffer stays full for the
   // output busy time and then counts as emptied
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         prtChar   <= 8'h00;
         prtStrobe <= 1'b0;
         outFull   <= 1'b0;
      end else if (clkEn) begin
         prtStrobe <= 1'b0;
         if (isOut & accept) begin
            prtChar   <= ioWord[7:0];
            prtStrobe <= 1'b1;
            outFull   <= 1'b1;
         end else if (outTmr.done) begin
            outFull <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Status, mask and interrupt outputs
   // ****************************************************************

   // Sticky events; a set in the same cycle as its clear wins
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status <= coupler_pkg::REG_RESET;
         mask   <= coupler_pkg::REG_RESET;
      end else if (clkEn) begin
         status <= status
                   & ~((regWr && regAddr == coupler_pkg::REG_STATUS)
                       ? regWrData : coupler_pkg::REG_RESET);
         if (inEvent) begin
            status[coupler_pkg::EV_INPUT] <= 1'b1;
         end
         if (outEvent) begin
            status[coupler_pkg::EV_OUTPUT] <= 1'b1;
         end
         if (regWr && regAddr == coupler_pkg::REG_MASK) begin
            mask <= regWrData;
         end
      end
   end

   // Level requests follow the pending event only while connected
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqLevel11 <= 1'b0;
         irqLevel12 <= 1'b0;
         irq        <= 1'b0;
      end else if (clkEn) begin
         irqLevel11 <= inConn & status[coupler_pkg::EV_INPUT];
         irqLevel12 <= outConn & status[coupler_pkg::EV_OUTPUT];
         irq        <= |(status & mask);
      end
   end

   // Register read data stand the cycle after the strobe only
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         regRdData <= coupler_pkg::REG_RESET;
      end else if (clkEn) begin
         regRdData <= coupler_pkg::REG_RESET;
         if (regRd) begin
            unique case (regAddr)
               coupler_pkg::REG_STATUS: regRdData <= status;
               coupler_pkg::REG_MASK:   regRdData <= mask;
               coupler_pkg::REG_STATE:  regRdData <= {1'b0, fetchPend, outFull, inFull,
                                                      kbdMode, rdrMode, outConn, inConn};
               default:                 regRdData <= coupler_pkg::REG_RESET;
            endcase
         end
      end
   end

endmodule : console_typewriter_coupler

// File: design/coupler_pkg.sv
package coupler_pkg;

   // ****************************************************************
   // Bus and unit decode
   // ****************************************************************
   localparam logic [5:0] UNIT_NUM     = 6'h01;   // Console coupler answers unit 1
   localparam int         XFER_CYCLES  = 4;       // Machine cycles the bus is held
   localparam logic [2:0] XFER_LAST    = 3'h3;    // Last count of a transfer

   // I/O instruction classes presented by the sequencer
   localparam logic [1:0] OP_COMMAND   = 2'h0;    // Command with second word
   localparam logic [1:0] OP_INPUT     = 2'h1;    // Input to accumulator or memory
   localparam logic [1:0] OP_OUTPUT    = 2'h2;    // Output from accumulator or memory

   // ****************************************************************
   // Command word bits, bit 0 is the most significant of 0-15
   // ****************************************************************
   localparam int CMD_CONNECT  = 14;   // Bit 1: connect (1) or disconnect (0)
   localparam int CMD_IN_SEL   = 13;   // Bit 2: input interrupt select
   localparam int CMD_OUT_SEL  = 12;   // Bit 3: output interrupt select
   localparam int CMD_READER   = 11;   // Bit 4: reader mode
   localparam int CMD_KEYBOARD = 10;   // Bit 5: keyboard mode
   localparam int CMD_MODE_CLR = 9;    // Bit 6: mode clear

   // ****************************************************************
   // Timing, in milliseconds at a 50 MHz clock
   // ****************************************************************
   localparam int unsigned CLK_KHZ         = 50_000;
   localparam int unsigned READER_BUSY_MS  = 50;
   localparam int unsigned KEYBOARD_BUSY_MS = 100;
   localparam int unsigned OUTPUT_BUSY_MS  = 100;
   localparam int unsigned TURNOFF_MS      = 12;   // Reader turn-off window
   localparam int          TMR_W           = 23;

   // ****************************************************************
   // Software register port
   // ****************************************************************
   localparam int         REG_W       = 8;
   localparam logic [1:0] REG_STATUS  = 2'h0;   // Sticky events, write one to clear
   localparam logic [1:0] REG_MASK    = 2'h1;   // Interrupt mask, same layout
   localparam logic [1:0] REG_STATE   = 2'h2;   // Read-only coupler state
   localparam int         EV_INPUT    = 0;      // New input character / connect
   localparam int         EV_OUTPUT   = 1;      // Output emptied / connect
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   typedef enum logic {SEQ_IDLE, SEQ_XFER} seq_e;

endpackage : coupler_pkg

// File: design/coupler_timer.sv
`timescale 1ns/10ps
module coupler_timer #(
   parameter int W = 23
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic clkEn,
   // Owner side
   timer_if.timer   tmr
);

   logic [W-1:0] count;
   logic         doneQ;

   // Down counter; a new start restarts it even while running
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
         doneQ <= 1'b0;
      end else if (clkEn) begin
         doneQ <= 1'b0;
         if (tmr.start) begin
            count <= tmr.load;
         end else if (count != '0) begin
            count <= count - W'(1);
            doneQ <= (count == W'(1));
         end
      end
   end

   assign tmr.remain  = count;
   assign tmr.running = (count != '0);
   assign tmr.done    = doneQ;

endmodule : coupler_timer

// File: design/timer_if.sv
`timescale 1ns/10ps
interface timer_if #(parameter int W = 23);
   logic         start;    // Load and start counting
   logic [W-1:0] load;     // Cycles to run
   logic [W-1:0] remain;   // Cycles left
   logic         running;  // Count not yet zero
   logic         done;     // One-cycle pulse as the count ends

   modport owner (output start, output load, input remain, input running, input done);
   modport timer (input start, input load, output remain, output running, output done);
endinterface : timer_if

// File: verif/coupler_properties.sv
`timescale 1ns/10ps
module coupler_checker (
   // Clock and reset
   input wire logic                          core_clk,
   input wire logic                          arst_n,
   input wire logic                          clkEn,
   // Watched ports
   input wire logic                          ioStart,
   input wire logic [5:0]                    ioUnit,
   input wire logic [1:0]                    ioOp,
   input wire logic [15:0]                   ioWord,
   input wire logic                          ioBusBusy,
   input wire logic                          ioDone,
   input wire logic                          ioSkip,
   input wire logic                          irqLevel11,
   input wire logic                          irqLevel12,
   input wire logic [7:0]                    prtChar,
   input wire logic                          prtStrobe,
   input wire logic                          regRd,
   input wire logic [coupler_pkg::REG_W-1:0] regRdData
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // A take needs an idle sequencer, so busy gates it
   wire taken = clkEn && ioStart && ioUnit == 6'h01 && !ioBusBusy;
   wire isCmd = taken && ioOp == coupler_pkg::OP_COMMAND;
   a_busy_span: assert property (taken |=> ioBusBusy[*3] ##[1:2] (ioDone && !ioBusBusy))
      else $error("transfer span wrong");
   a_done_pulse: assert property (ioDone |=> !ioDone)
      else $error("done longer than one cycle");
   a_other_unit: assert property (ioStart && ioUnit != 6'h01 && !ioBusBusy |=> !ioBusBusy)
      else $error("foreign unit answered");
   a_print_char: assert property (prtStrobe |-> ioSkip && prtChar == $past(ioWord[7:0])
      && $past(taken && ioOp == coupler_pkg::OP_OUTPUT))
      else $error("print without output take");
   a_conn_input: assert property (isCmd && ioWord == 16'h6000 |-> ##[1:3] irqLevel11)
      else $error("input connect gave no request");
   a_conn_output: assert property (isCmd && ioWord == 16'h5000 |-> ##[1:3] irqLevel12)
      else $error("output connect gave no request");
   a_disc_input: assert property (isCmd && ioWord == 16'h2000 |-> ##2 (!irqLevel11)[*2])
      else $error("input request after disconnect");
   a_disc_output: assert property (isCmd && ioWord == 16'h1000 |-> ##2 (!irqLevel12)[*2])
      else $error("output request after disconnect");
   a_read_idle: assert property (!$past(regRd) |-> regRdData == 8'h00)
      else $error("read data outside read slot");
endmodule : coupler_checker

bind console_typewriter_coupler coupler_checker coupler_checker_inst (
   .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn), .ioStart(ioStart), .ioUnit(ioUnit),
   .ioOp(ioOp), .ioWord(ioWord), .ioBusBusy(ioBusBusy), .ioDone(ioDone), .ioSkip(ioSkip),
   .irqLevel11(irqLevel11), .irqLevel12(irqLevel12), .prtChar(prtChar),
   .prtStrobe(prtStrobe), .regRd(regRd), .regRdData(regRdData));

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   localparam int unsigned OUT_CYC = 80;
   logic        core_clk, arst_n, ioStart, ioBusBusy, ioDone, ioSkip, irqLevel11, irqLevel12;
   logic        rdrAdvance, prtStrobe, kbdStrobe, rdrStrobe, regWr, regRd, irq, skip, clkEn;
   logic [5:0]  ioUnit;
   logic [1:0]  ioOp, regAddr;
   logic [15:0] ioWord, ioInData;
   logic [7:0]  devChar, prtChar, regWrData, regRdData, c;
   logic [31:0] seed;
   int          n_mismatch, total_checks;
   console_typewriter_coupler #(.READER_CYC(40), .KEYBOARD_CYC(80), .OUTPUT_CYC(OUT_CYC),
      .TURNOFF_CYC(10)) console_typewriter_coupler_inst (.core_clk(core_clk), .arst_n(arst_n),
      .clkEn(clkEn), .ioStart(ioStart), .ioUnit(ioUnit), .ioOp(ioOp), .ioWord(ioWord),
      .ioBusBusy(ioBusBusy), .ioDone(ioDone), .ioSkip(ioSkip), .ioInData(ioInData),
      .irqLevel11(irqLevel11), .irqLevel12(irqLevel12), .devChar(devChar),
      .kbdStrobe(kbdStrobe), .rdrStrobe(rdrStrobe), .rdrAdvance(rdrAdvance),
      .prtChar(prtChar), .prtStrobe(prtStrobe), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));
   typewriter_model typewriter_model_inst (.core_clk(core_clk), .rdrAdvance(rdrAdvance),
      .prtChar(prtChar), .prtStrobe(prtStrobe), .devChar(devChar), .kbdStrobe(kbdStrobe),
      .rdrStrobe(rdrStrobe));
   function automatic logic [31:0] nextRnd(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : nextRnd
   // Input data word carries the character in the low byte
   function automatic logic [15:0] inWord(input logic [7:0] ch);
      return {8'h00, ch};
   endfunction : inWord
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic io(input logic [1:0] op, input logic [15:0] w);
      @(posedge core_clk);
      ioStart <= 1'b1;
      ioOp <= op;
      ioWord <= w;
      @(posedge core_clk);
      ioStart <= 1'b0;
      repeat (8) begin
         @(negedge core_clk);
         if (ioDone === 1'b1) break;
      end
      chk("ioDone", 16'h0001, {15'h0000, ioDone});
      skip = ioSkip;
   endtask : io
   task automatic regW(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : regW
   task automatic regR(input logic [1:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(negedge core_clk);
      chk("regRdData", {8'h00, exp}, {8'h00, regRdData});
   endtask : regR
   task automatic test_done;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Watchdog: whole sequence needs well under 3000 cycles
   initial begin
      cyc(5000);
      n_mismatch++;
      test_done;
   end
   // **************************************************
   // Main sequence
   // **************************************************
   initial begin
      {ioStart, ioOp, ioWord, regWr, regRd, regAddr, regWrData, arst_n} = '0;
      ioUnit = 6'h01;
      clkEn = 1'b1;
      seed = 32'h0001_1D48;
      n_mismatch = 0;
      total_checks = 0;
      cyc(16);
      arst_n <= 1'b1;
      for (int a = 0; a < 4; a++) regR(a[1:0], 8'h00);
      regW(2'h3, 8'hFF);
      regR(2'h3, 8'h00);
      regW(2'h1, 8'h03);
      regR(2'h1, 8'h03);
      io(coupler_pkg::OP_COMMAND, 16'h0000);
      chk("zeroSkip", 16'h0001, {15'h0000, skip});
      regR(2'h2, 8'h00);
      // Foreign unit: checker sees no answer
      @(posedge core_clk);
      ioUnit <= 6'h02;
      ioStart <= 1'b1;
      @(posedge core_clk);
      ioStart <= 1'b0;
      ioUnit <= 6'h01;
      io(coupler_pkg::OP_COMMAND, 16'h0800);
      chk("cmdSkip", 16'h0001, {15'h0000, skip});
      for (int i = 0; i < 3; i++) begin
         cyc(60);
         io(coupler_pkg::OP_INPUT, 16'h0000);
         chk("tapeChar", inWord(8'h30 + i[7:0]), ioInData);
      end
      // Late turn-off: the extra character is read and then lost
      cyc(60);
      regR(2'h2, 8'h14);
      io(coupler_pkg::OP_COMMAND, 16'h0400);
      io(coupler_pkg::OP_INPUT, 16'h0000);
      chk("clearSkip", 16'h0000, {15'h0000, skip});
      // Host connects the input interrupt, then clears the connect event
      io(coupler_pkg::OP_COMMAND, 16'h6000);
      regW(2'h0, 8'h01);
      cyc(3);
      chk("lvl11Clr", 16'h0000, {15'h0000, irqLevel11});
      seed = nextRnd(seed);
      c = seed[7:0];
      typewriter_model_inst.strike(c, 1'b0);
      cyc(3);
      chk("lvl11Key", 16'h0001, {15'h0000, irqLevel11});
      io(coupler_pkg::OP_INPUT, 16'h0000);
      chk("keyChar", inWord(c), ioInData);
      io(coupler_pkg::OP_OUTPUT, inWord(c));
      chk("outSkip", 16'h0001, {15'h0000, skip});
      chk("printed", inWord(c), inWord(typewriter_model_inst.lastPrt));
      io(coupler_pkg::OP_OUTPUT, 16'h0055);
      chk("busySkip", 16'h0000, {15'h0000, skip});
      io(coupler_pkg::OP_COMMAND, 16'h0000);
      chk("zeroBusy", 16'h0000, {15'h0000, skip});
      cyc(1);
      clkEn <= 1'b0;
      cyc(OUT_CYC);
      clkEn <= 1'b1;
      regR(2'h0, 8'h01);
      cyc(OUT_CYC);
      regR(2'h0, 8'h03);
      chk("irq", 16'h0001, {15'h0000, irq});
      io(coupler_pkg::OP_COMMAND, 16'h0000);
      chk("zeroIdle", 16'h0001, {15'h0000, skip});
      regW(2'h0, 8'h02);
      io(coupler_pkg::OP_COMMAND, 16'h5000);
      cyc(2);
      chk("lvl12", 16'h0001, {15'h0000, irqLevel12});
      io(coupler_pkg::OP_COMMAND, 16'h1000);
      io(coupler_pkg::OP_COMMAND, 16'h2000);
      regW(2'h0, 8'h03);
      cyc(3);
      chk("irqOff", 16'h0000, {15'h0000, irq});
      io(coupler_pkg::OP_COMMAND, 16'h0200);
      seed = nextRnd(seed);
      typewriter_model_inst.strike(seed[7:0], 1'b0);
      io(coupler_pkg::OP_INPUT, 16'h0000);
      chk("offSkip", 16'h0000, {15'h0000, skip});
      test_done;
   end
endmodule : testbench

// File: verif/typewriter_model.sv
`timescale 1ns/10ps
module typewriter_model (
   // Clock
   input wire logic       core_clk,
   // Coupler side
   input wire logic       rdrAdvance,
   input wire logic [7:0] prtChar,
   input wire logic       prtStrobe,
   output     logic [7:0] devChar,
   output     logic       kbdStrobe,
   output     logic       rdrStrobe
);
   logic [7:0] lastPrt;
   int         tapePos;
   initial begin
      devChar = 8'h00;
      kbdStrobe = 1'b0;
      rdrStrobe = 1'b0;
      lastPrt = 8'h00;
      tapePos = 0;
   end
   // Printer keeps the last character handed over
   always @(posedge core_clk) begin
      if (prtStrobe) begin
         lastPrt <= prtChar;
      end
   end
   // Data settle before the strobe; released pins show the inverse, not the old char
   task automatic strike(input logic [7:0] c, input bit rdr);
      @(posedge core_clk);
      devChar <= c;
      repeat (2) @(posedge core_clk);
      if (rdr) rdrStrobe <= 1'b1;
      else kbdStrobe <= 1'b1;
      repeat (6) @(posedge core_clk);
      kbdStrobe <= 1'b0;
      rdrStrobe <= 1'b0;
      devChar <= ~c;
   endtask : strike
   // Reader sends the next tape character once per advance pulse
   always @(posedge core_clk) begin
      if (rdrAdvance) begin
         strike(8'h30 + tapePos[7:0], 1'b1);
         tapePos <= tapePos + 1;
      end
   end
endmodule : typewriter_model
